// ### rtl/lcdtg_pkg.sv
/*
 * Constants for the monochrome LCD panel timing generator: register
 * offsets, field positions, reset values and panel data width codes.
 * Assumes a 32-bit APB slave port with byte addresses and word registers.
 */
// Functional notes
// - The prescale tick comes every two-to-the-prescale_select cycles.
// - A shift clock period lasts shift_period_count plus one ticks.
// - The shift clock is high for shift_high_count plus one ticks.
// - The line clock rises line_rise_delay plus one ticks after the rise.
// - The line clock falls line_fall_delay plus one ticks after the rise.
// - A line lasts horizontal count plus one, times W, shift periods.
// - Frame rises two shift clocks after the last line's line clock.
// - Frame falls two shift clocks after the first line's line clock.
// - A frame lasts twice vertical count plus one line periods.
// - Panel data changes at the shift clock rise and holds a period.
package lcdtg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] LCDTG_CTRL_OFS = 8'h00;
  localparam logic [7:0] LCDTG_SHIFT_OFS = 8'h04;
  localparam logic [7:0] LCDTG_LINE_OFS = 8'h08;
  localparam logic [7:0] LCDTG_RES_OFS = 8'h0C;
  localparam logic [7:0] LCDTG_STAT_OFS = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LCDTG_EN_BIT = 0;
  localparam int LCDTG_WID_LSB = 1;
  localparam int LCDTG_PSEL_LSB = 4;
  localparam int LCDTG_PER_LSB = 0;
  localparam int LCDTG_HIGH_LSB = 8;
  localparam int LCDTG_LRISE_LSB = 0;
  localparam int LCDTG_LFALL_LSB = 8;
  localparam int LCDTG_HRES_LSB = 0;
  localparam int LCDTG_VRES_LSB = 8;
  localparam int LCDTG_FRM_BIT = 9;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] LCDTG_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LCDTG_SHIFT_RST = 32'h0000_0103;
  localparam logic [31:0] LCDTG_LINE_RST = 32'h0000_0200;
  localparam logic [31:0] LCDTG_RES_RST = 32'h0000_C74F;

  // ****************************************
  // Panel data width codes
  // ****************************************
  localparam logic [1:0] LCDTG_BUS1 = 2'h0;
  localparam logic [1:0] LCDTG_BUS2 = 2'h1;
  localparam logic [1:0] LCDTG_BUS4 = 2'h2;

endpackage

// ### rtl/lcdtg_prescaler.sv
/*
 * Power-of-two prescaler giving a one-cycle tick enable.
 * Assumes prescale_select is held steady while enabled.
 */
`timescale 1ns/100ps
module lcdtg_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] prescale_select,
  output logic tick
);
  import lcdtg_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] limit;
  logic [7:0] gap_r;

  assign limit = 7'((8'h01 << prescale_select) - 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 7'h00;
    end else if (!run || cnt_r >= limit) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  assign tick = run && (cnt_r >= limit);

  // Cycles since the previous tick, read by the check below only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 8'h00;
    end else if (!run || tick) begin
      gap_r <= 8'h01;
    end else if (gap_r != 8'hFF) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn)
    run && $past(run) && $stable(prescale_select) && tick && $past(run, 2)
      && !$past(tick) |-> gap_r == (8'h01 << prescale_select);
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("prescale tick spacing wrong");

endmodule

// ### rtl/lcdtg_shift_gen.sv
/*
 * Shift clock generator counting prescale ticks.
 * Assumes the period and high counts are held steady while running.
 */
`timescale 1ns/100ps
module lcdtg_shift_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic tick,
  input wire logic [4:0] shift_period_count,
  input wire logic [4:0] shift_high_count,
  output logic shift_level,
  output logic shift_rise
);
  import lcdtg_pkg::*;

  logic [4:0] ph_r;
  logic act_r;
  logic wrap;
  logic [4:0] ph_nxt;
  logic [5:0] hi_ticks_r;

  assign wrap = !act_r || ph_r >= shift_period_count;
  assign ph_nxt = wrap ? 5'h00 : ph_r + 5'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 5'h00;
      act_r <= 1'b0;
      shift_rise <= 1'b0;
      shift_level <= 1'b0;
    end else if (!run) begin
      ph_r <= 5'h00;
      act_r <= 1'b0;
      shift_rise <= 1'b0;
      shift_level <= 1'b0;
    end else begin
      shift_rise <= tick && wrap;
      if (tick) begin
        ph_r <= ph_nxt;
        act_r <= 1'b1;
        shift_level <= ph_nxt <= shift_high_count;
      end
    end
  end

  // Ticks seen while the shift clock is high, for the check only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_ticks_r <= 6'h00;
    end else if (shift_rise) begin
      // Only at the fastest rate does a tick fall in the rise's own cycle.
      hi_ticks_r <= tick ? 6'h01 : 6'h00;
    end else if (tick && shift_level && hi_ticks_r != 6'h3F) begin
      hi_ticks_r <= hi_ticks_r + 6'h01;
    end
  end

  property p_high_len;
    @(posedge pclk) disable iff (!presetn)
    run && $fell(shift_level) && shift_high_count < shift_period_count
      |-> hi_ticks_r == {1'b0, shift_high_count} + 6'h01;
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("shift clock high time wrong");

  property p_rise_phase;
    @(posedge pclk) disable iff (!presetn)
    shift_rise |-> ph_r == 5'h00 && shift_level;
  endproperty
  a_rise_phase: assert property (p_rise_phase)
    else $error("shift rise not at phase zero");

endmodule

// ### rtl/lcdtg_top.sv
/*
 * LCD panel timing generator with its APB register file.
 * Assumes one 50 MHz clock, APB master timing, and a pixel source that
 * presents the next nibble on pixel_nibble before each data request.
 */
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module lcdtg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] pixel_nibble,
  output logic pixel_request,
  output logic [3:0] panel_data,
  output logic panel_shift_clock,
  output logic panel_line_clock,
  output logic panel_frame
);
  import lcdtg_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  logic [31:0] ctrl_r;
  logic [31:0] shift_r;
  logic [31:0] line_r;
  logic [31:0] res_r;
  logic [31:0] rdata_nxt;
  logic wr_en;
  logic setup_ph;
  logic hit_ctrl;
  logic hit_shift;
  logic hit_line;
  logic hit_res;
  logic hit_stat;
  logic hit_any;

  logic enable;
  logic [1:0] width_sel;
  logic [2:0] prescale_select;
  logic [4:0] shift_period_count;
  logic [4:0] shift_high_count;
  logic [4:0] line_rise_delay;
  logic [4:0] line_fall_delay;
  logic [7:0] horizontal_resolution_count;
  logic [7:0] vertical_resolution_count;

  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign hit_ctrl = paddr == LCDTG_CTRL_OFS;
  assign hit_shift = paddr == LCDTG_SHIFT_OFS;
  assign hit_line = paddr == LCDTG_LINE_OFS;
  assign hit_res = paddr == LCDTG_RES_OFS;
  assign hit_stat = paddr == LCDTG_STAT_OFS;
  assign hit_any = hit_ctrl || hit_shift || hit_line || hit_res || hit_stat;

  assign enable = ctrl_r[LCDTG_EN_BIT];
  assign width_sel = ctrl_r[LCDTG_WID_LSB +: 2];
  assign prescale_select = ctrl_r[LCDTG_PSEL_LSB +: 3];
  assign shift_period_count = shift_r[LCDTG_PER_LSB +: 5];
  assign shift_high_count = shift_r[LCDTG_HIGH_LSB +: 5];
  assign line_rise_delay = line_r[LCDTG_LRISE_LSB +: 5];
  assign line_fall_delay = line_r[LCDTG_LFALL_LSB +: 5];
  assign horizontal_resolution_count = res_r[LCDTG_HRES_LSB +: 8];
  assign vertical_resolution_count = res_r[LCDTG_VRES_LSB +: 8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= LCDTG_CTRL_RST;
      shift_r <= LCDTG_SHIFT_RST;
      line_r <= LCDTG_LINE_RST;
      res_r <= LCDTG_RES_RST;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_r <= pwdata & 32'h0000_007F;
      if (hit_shift) shift_r <= pwdata & 32'h0000_1F1F;
      if (hit_line) line_r <= pwdata & 32'h0000_1F1F;
      if (hit_res) res_r <= pwdata & 32'h0000_FFFF;
    end
  end

  // ****************************************
  // Timing state
  // ****************************************
  logic tick;
  logic shift_level;
  logic shift_rise;
  logic [8:0] hsum;
  logic [10:0] hlimit;
  logic [10:0] hcnt_r;
  logic [8:0] vsum;
  logic [9:0] vlimit;
  logic tick_d_r;
  logic [8:0] vcnt_r;
  logic line_start;
  logic [5:0] lcnt_r;
  logic [5:0] lcnt_nxt;
  logic lact_r;
  logic line_first_r;
  logic line_last_r;
  logic line_set;
  logic line_clr;
  logic [1:0] fr_cnt_r;
  logic fr_pend_r;
  logic fr_level_r;

  // Register read data is assembled during the setup cycle so that the
  // answer is ready in the access cycle with no wait state.
  assign rdata_nxt = hit_ctrl ? ctrl_r :
                     hit_shift ? shift_r :
                     hit_line ? line_r :
                     hit_res ? res_r :
                     hit_stat ? {22'h0, panel_frame, 1'b0, vcnt_r[7:0]} :
                     32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      if (setup_ph) prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
    end
  end

  lcdtg_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .run(enable),
    .prescale_select(prescale_select),
    .tick(tick)
  );

  lcdtg_shift_gen u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .run(enable),
    .tick(tick),
    .shift_period_count(shift_period_count),
    .shift_high_count(shift_high_count),
    .shift_level(shift_level),
    .shift_rise(shift_rise)
  );

  assign hsum = {1'b0, horizontal_resolution_count} + 9'h001;
  assign hlimit = (width_sel == LCDTG_BUS1) ? {hsum, 2'b00} :
                  (width_sel == LCDTG_BUS2) ? {1'b0, hsum, 1'b0} :
                  {2'b00, hsum};
  // A full frame can hold 512 lines, so the limit needs ten bits.
  assign vsum = {1'b0, vertical_resolution_count} + 9'h001;
  assign vlimit = {vsum, 1'b0};
  assign line_start = shift_rise && hcnt_r == 11'h000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_r <= 11'h000;
      vcnt_r <= 9'h000;
    end else if (!enable) begin
      hcnt_r <= 11'h000;
      vcnt_r <= 9'h000;
    end else if (shift_rise) begin
      if (hcnt_r + 11'h001 >= hlimit) begin
        hcnt_r <= 11'h000;
        vcnt_r <= ({1'b0, vcnt_r} + 10'h001 >= vlimit) ? 9'h000 :
                  vcnt_r + 9'h001;
      end else begin
        hcnt_r <= hcnt_r + 11'h001;
      end
    end
  end

  // Ticks are counted from the one that launched the opening shift rise.
  // The line clock acts one cycle after the count moves, because the
  // shift clock also lags its own tick by two registers.
  assign lcnt_nxt = lcnt_r + 6'h01;
  assign line_set = lact_r && tick_d_r &&
                    lcnt_r == {1'b0, line_rise_delay} + 6'h01;
  assign line_clr = lact_r && tick_d_r &&
                    lcnt_r == {1'b0, line_fall_delay} + 6'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt_r <= 6'h00;
      lact_r <= 1'b0;
      line_first_r <= 1'b0;
      line_last_r <= 1'b0;
    end else if (!enable) begin
      lcnt_r <= 6'h00;
      lact_r <= 1'b0;
      line_first_r <= 1'b0;
      line_last_r <= 1'b0;
    end else if (line_start) begin
      lcnt_r <= {5'h00, tick};
      lact_r <= 1'b1;
      line_first_r <= vcnt_r == 9'h000;
      line_last_r <= {1'b0, vcnt_r} + 10'h001 >= vlimit;
    end else if (lact_r && tick) begin
      lcnt_r <= lcnt_nxt;
      if (lcnt_r > {1'b0, line_rise_delay} &&
          lcnt_r > {1'b0, line_fall_delay}) begin
        lact_r <= 1'b0;
      end
    end
  end

  // Marks the cycle in which the line count has just moved.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick;
    end
  end

  // A line clock pulse that saw both the last and the first line would
  // raise the frame, as the last line wins; a frame holds two lines or more.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_cnt_r <= 2'h0;
      fr_pend_r <= 1'b0;
      fr_level_r <= 1'b0;
    end else if (!enable) begin
      fr_cnt_r <= 2'h0;
      fr_pend_r <= 1'b0;
      fr_level_r <= 1'b0;
    end else if (line_set && (line_last_r || line_first_r)) begin
      fr_cnt_r <= 2'h0;
      fr_pend_r <= 1'b1;
      fr_level_r <= line_last_r;
    end else if (fr_pend_r && shift_rise) begin
      fr_cnt_r <= fr_cnt_r + 2'h1;
      if (fr_cnt_r == 2'h1) begin
        fr_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Panel outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_shift_clock <= 1'b0;
      panel_line_clock <= 1'b0;
      panel_frame <= 1'b0;
      panel_data <= 4'h0;
      pixel_request <= 1'b0;
    end else if (!enable) begin
      panel_shift_clock <= 1'b0;
      panel_line_clock <= 1'b0;
      panel_frame <= 1'b0;
      pixel_request <= 1'b0;
    end else begin
      panel_shift_clock <= shift_level;
      if (line_set) panel_line_clock <= 1'b1;
      else if (line_clr) panel_line_clock <= 1'b0;
      if (fr_pend_r && shift_rise && fr_cnt_r == 2'h1) begin
        panel_frame <= fr_level_r;
      end
      pixel_request <= shift_rise;
      if (shift_rise) panel_data <= pixel_nibble;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_line_rise;
    @(posedge pclk) disable iff (!presetn)
    $rose(panel_line_clock) |-> $past(lcnt_r)
      == {1'b0, line_rise_delay} + 6'h01;
  endproperty
  a_line_rise: assert property (p_line_rise)
    else $error("line clock rise delay wrong");

  property p_line_fall;
    @(posedge pclk) disable iff (!presetn)
    enable && $past(enable) && $fell(panel_line_clock)
      |-> $past(lcnt_r) == {1'b0, line_fall_delay} + 6'h01;
  endproperty
  a_line_fall: assert property (p_line_fall)
    else $error("line clock fall delay wrong");

  property p_hcnt_range;
    @(posedge pclk) disable iff (!presetn)
    enable |-> hcnt_r < hlimit;
  endproperty
  a_hcnt_range: assert property (p_hcnt_range)
    else $error("horizontal count out of range");

  property p_width_w;
    @(posedge pclk) disable iff (!presetn)
    width_sel == LCDTG_BUS1 |->
      hlimit == 11'(({3'b000, horizontal_resolution_count} + 11'h001) << 2);
  endproperty
  a_width_w: assert property (p_width_w)
    else $error("width factor for 1-bit bus wrong");

  property p_frame_set;
    @(posedge pclk) disable iff (!presetn)
    $rose(panel_frame) |-> line_last_r && $past(shift_rise);
  endproperty
  a_frame_set: assert property (p_frame_set)
    else $error("frame raised outside last line");

  property p_frame_clr;
    @(posedge pclk) disable iff (!presetn)
    enable && $fell(panel_frame) |-> line_first_r && $past(shift_rise);
  endproperty
  a_frame_clr: assert property (p_frame_clr)
    else $error("frame dropped outside first line");

  property p_vcnt_range;
    @(posedge pclk) disable iff (!presetn)
    enable |-> {1'b0, vcnt_r} < vlimit;
  endproperty
  a_vcnt_range: assert property (p_vcnt_range)
    else $error("vertical count out of range");

  property p_data_launch;
    @(posedge pclk) disable iff (!presetn)
    $changed(panel_data) |-> $rose(panel_shift_clock) && pixel_request;
  endproperty
  a_data_launch: assert property (p_data_launch)
    else $error("panel data changed off the shift rise");

  property p_idle_low;
    @(posedge pclk) disable iff (!presetn)
    !enable |-> ##1 !panel_shift_clock && !panel_line_clock && !panel_frame;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("strobes not low while disabled");

endmodule

// ### sim/lcdtg_panel_model.sv
/*
 * Behavioural monochrome panel that measures the strobes it receives.
 * Assumes all strobes and panel_data are launched on rising pclk edges.
 */
`timescale 1ns/100ps
module lcdtg_panel_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] panel_data,
  input wire logic panel_shift_clock,
  input wire logic panel_line_clock,
  input wire logic panel_frame,
  output int sh_per,
  output int sh_high,
  output int ln_rise,
  output int ln_fall,
  output int ln_per,
  output int fr_per,
  output int fr_on,
  output int fr_off,
  output int fr_count,
  output int data_err,
  output int data_chg
);
  logic sc_q, lc_q, fr_q, sr;
  logic [3:0] pd_q;
  int c_sh, c_ln, c_fr, n_sh;

  // The panel samples data at the falling shift edge, so data may only
  // move together with the rising edge.
  assign sr = panel_shift_clock && !sc_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q <= 1'b0; lc_q <= 1'b0; fr_q <= 1'b0; pd_q <= 4'h0;
      c_sh <= 0; c_ln <= 0; c_fr <= 0; n_sh <= 0;
      fr_count <= 0; data_err <= 0; data_chg <= 0;
    end else begin
      sc_q <= panel_shift_clock; lc_q <= panel_line_clock;
      fr_q <= panel_frame; pd_q <= panel_data;
      c_sh <= c_sh + 1; c_ln <= c_ln + 1; c_fr <= c_fr + 1;
      if (sr) begin sh_per <= c_sh; c_sh <= 1; n_sh <= n_sh + 1; end
      if (!panel_shift_clock && sc_q) sh_high <= c_sh;
      if (panel_line_clock && !lc_q) begin
        ln_rise <= c_sh; ln_per <= c_ln; c_ln <= 1; n_sh <= 0;
      end
      if (!panel_line_clock && lc_q) ln_fall <= c_sh;
      if (panel_frame && !fr_q) begin
        fr_per <= c_fr; c_fr <= 1; fr_count <= fr_count + 1;
        fr_on <= n_sh + int'(sr);
      end
      if (!panel_frame && fr_q) fr_off <= n_sh + int'(sr);
      if (panel_data != pd_q) begin
        data_chg <= data_chg + 1;
        if (!sr) data_err <= data_err + 1;
      end
    end
  end
endmodule

// ### sim/tb_lcd_panel_timing_generator.sv
/*
 * Self-checking bench for the panel timing generator.
 * Assumes the APB slave and the panel model measure in pclk cycles.
 */
`timescale 1ns/100ps
module tb_lcd_panel_timing_generator;
  import lcdtg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pixel_nibble, panel_data;
  logic pixel_request, panel_shift_clock, panel_line_clock, panel_frame;
  int sh_per, sh_high, ln_rise, ln_fall, ln_per, fr_per, fr_on, fr_off;
  int fr_count, data_err, data_chg, err_count, total_checks, cyc;

  lcdtg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_nibble(pixel_nibble), .pixel_request(pixel_request),
    .panel_data(panel_data), .panel_shift_clock(panel_shift_clock),
    .panel_line_clock(panel_line_clock), .panel_frame(panel_frame));
  lcdtg_panel_model i_panel (.pclk(pclk), .presetn(presetn),
    .panel_data(panel_data), .panel_shift_clock(panel_shift_clock),
    .panel_line_clock(panel_line_clock), .panel_frame(panel_frame),
    .sh_per(sh_per), .sh_high(sh_high), .ln_rise(ln_rise),
    .ln_fall(ln_fall), .ln_per(ln_per), .fr_per(fr_per), .fr_on(fr_on),
    .fr_off(fr_off), .fr_count(fr_count), .data_err(data_err),
    .data_chg(data_chg));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Pixel source and watchdog
  // ****************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pixel_request === 1'b1) pixel_nibble <= pixel_nibble + 4'h1;
    if (cyc == 60000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // APB master
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    if (n == 20) begin
      err_count++;
      conclude();
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
    check({31'h0, e}, {31'h0, ex});
  endtask

  task automatic strobes_low();
    check({28'h0, panel_shift_clock, panel_line_clock, panel_frame,
           pixel_request}, 32'h0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    strobes_low();
    rd(LCDTG_CTRL_OFS, LCDTG_CTRL_RST, 1'b0);
    rd(LCDTG_SHIFT_OFS, LCDTG_SHIFT_RST, 1'b0);
    rd(LCDTG_LINE_OFS, LCDTG_LINE_RST, 1'b0);
    rd(LCDTG_RES_OFS, LCDTG_RES_RST, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    wr(LCDTG_SHIFT_OFS, 32'hFFFF_FFFF);
    rd(LCDTG_SHIFT_OFS, 32'h0000_1F1F, 1'b0);
    $display("test registers done");
  endtask

  task automatic run(input int sel, input logic [1:0] wc, input int per,
                     input int hi, input int rs, input int fl,
                     input int hr, input int vr);
    int t, w, f0, n;
    t = 1 << sel;
    w = (wc == LCDTG_BUS1) ? 4 : (wc == LCDTG_BUS2) ? 2 : 1;
    wr(LCDTG_CTRL_OFS, 32'h0);
    wr(LCDTG_SHIFT_OFS, 32'(per) | (32'(hi) << LCDTG_HIGH_LSB));
    wr(LCDTG_LINE_OFS, 32'(rs) | (32'(fl) << LCDTG_LFALL_LSB));
    wr(LCDTG_RES_OFS, 32'(hr) | (32'(vr) << LCDTG_VRES_LSB));
    wr(LCDTG_CTRL_OFS, 32'h1 | (32'(wc) << LCDTG_WID_LSB) |
       (32'(sel) << LCDTG_PSEL_LSB));
    f0 = fr_count;
    n = 0;
    while (fr_count < f0 + 3 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20000) begin
      err_count++;
      conclude();
    end
    check(sh_per, (per + 1) * t);
    check(sh_high, (hi + 1) * t);
    check(ln_rise, (rs + 1) * t);
    check(ln_fall, (fl + 1) * t);
    check(ln_per, (hr + 1) * w * (per + 1) * t);
    check(fr_on, 2);
    check(fr_off, 2);
    check(fr_per, 2 * (vr + 1) * (hr + 1) * w * (per + 1) * t);
    check(data_err, 0);
    check(32'(data_chg > 0), 32'h1);
    $display("test run sel %0d width %0d done", sel, wc);
  endtask

  task automatic t_stop();
    wr(LCDTG_CTRL_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    strobes_low();
    run(0, LCDTG_BUS4, 3, 1, 0, 2, 3, 1);
    presetn <= 1'b0;
    @(posedge pclk);
    strobes_low();
    presetn <= 1'b1;
    rd(LCDTG_CTRL_OFS, LCDTG_CTRL_RST, 1'b0);
    $display("test stop done");
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pixel_nibble = 4'h0;
    err_count = 0; total_checks = 0; cyc = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    run(0, LCDTG_BUS4, 3, 1, 0, 2, 3, 1);
    run(2, LCDTG_BUS1, 5, 2, 1, 4, 1, 0);
    run(1, LCDTG_BUS2, 2, 0, 0, 1, 2, 2);
    for (int s = 0; s < 8; s++) run(s, LCDTG_BUS4, 2, 0, 0, 1, 2, 0);
    t_stop();
    conclude();
  end
endmodule
